// File: hdl/cpmd_defs.svh
// Constants for the control pin mode decoder: widths and reset values.
`ifndef CPMD_DEFS_SVH
`define CPMD_DEFS_SVH

`define CPMD_MB_W 7
`define CPMD_SYNC_W 17
`define CPMD_MUTE_RST 1'h1
`define CPMD_CS_IDLE 1'h1
`define CPMD_CLK_IDLE 1'h0
`define CPMD_DATA_IDLE 1'h0
`define CPMD_SPEED_RST 1'h0
`define CPMD_FMT_RST 1'h0
`define CPMD_SOUND_RST 1'h1
`define CPMD_ADDR_RST 1'h0
`define CPMD_WORD_RST 7'h00

`endif

// File: hdl/cpmd_pkg.sv
// Types shared by the control pin mode decoder files.
package cpmd_pkg;
	typedef enum logic {
		CPMD_REGISTER_CTRL,
		CPMD_PIN_CTRL
	} cpmd_mode_e;

	typedef enum logic [1:0] {
		CPMD_SER_NONE,
		CPMD_SER_3WIRE,
		CPMD_SER_I2C
	} cpmd_serial_e;
endpackage

// File: hdl/cpmd_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
module cpmd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rstN,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			stage1_reg <= '0;
			q <= '0;
		end else begin
			stage1_reg <= d;
			q <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

// File: hdl/cpmd_decoder.sv
// Decoder for the dual-purpose control pins of a multi-bit stereo DAC.
`timescale 1ns/10ps
`default_nettype none
`include "cpmd_defs.svh"

module cpmd_decoder (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic powerDownN,
	input wire logic controlStyleSelect,
	input wire logic speedSelect,
	input wire logic chipSelectFormat0Pin,
	input wire logic serialClockFormat1Pin,
	input wire logic serialDataPinIn,
	input wire logic muteNA,
	input wire logic soundAddr0Pin,
	input wire logic testAddr1Pin,
	input wire logic serialTypeSelect,
	input wire logic multibitBitClock,
	input wire logic [`CPMD_MB_W-1:0] multibitDataIn,
	input wire logic i2cSdaDriveLow,
	output cpmd_pkg::cpmd_mode_e controlMode,
	output cpmd_pkg::cpmd_serial_e serialPort,
	output logic oversample256Mode,
	output logic oversample128Mode,
	output logic formatSelect0,
	output logic formatSelect1,
	output logic soundCharacterSelect,
	output logic muteActive,
	output logic ctrlChipSelectN,
	output logic ctrlSerialClock,
	output logic ctrlSerialDataIn,
	output logic i2cScl,
	output logic i2cSdaIn,
	output logic serialDataPinOut,
	output logic serialDataPinOe,
	output logic chipAddrBit0,
	output logic chipAddrBit1,
	output logic testOutput,
	output logic [`CPMD_MB_W-1:0] multibitWord,
	output logic multibitStrobe
);
	import cpmd_pkg::*;

	logic coreRstN;
	logic [`CPMD_SYNC_W-1:0] pinsSync;
	logic styleS, speedS, sh0S, sh1S, sdaS, muteS, soundS, t18S, i2cSelS, bclkS;
	logic [`CPMD_MB_W-1:0] dataS;
	logic bclkPrev_reg;
	logic bclkRise;

	function automatic cpmd_serial_e serialKind(input logic pinMode,
			input logic i2cSel);
		if (pinMode) begin
			return CPMD_SER_NONE;
		end
		return i2cSel ? CPMD_SER_I2C : CPMD_SER_3WIRE;
	endfunction

	// Power-down clears at once and releases in step with the clock.
	cpmd_sync #(.WIDTH(1)) resetSync (
		.clock(clock),
		.rstN(reset_n & powerDownN),
		.d(1'h1),
		.q(coreRstN)
	);

	cpmd_sync #(.WIDTH(`CPMD_SYNC_W)) pinSync (
		.clock(clock),
		.rstN(coreRstN),
		.d({controlStyleSelect, speedSelect, chipSelectFormat0Pin,
			serialClockFormat1Pin, serialDataPinIn, muteNA, soundAddr0Pin,
			testAddr1Pin, serialTypeSelect, multibitBitClock, multibitDataIn}),
		.q(pinsSync)
	);

	assign {styleS, speedS, sh0S, sh1S, sdaS, muteS, soundS, t18S, i2cSelS,
		bclkS, dataS} = pinsSync;
	assign bclkRise = bclkS & ~bclkPrev_reg;

	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			controlMode <= CPMD_REGISTER_CTRL;
			serialPort <= CPMD_SER_NONE;
		end else begin
			controlMode <= styleS ? CPMD_PIN_CTRL : CPMD_REGISTER_CTRL;
			serialPort <= serialKind(styleS, i2cSelS);
		end
	end

	// Pin-control settings freeze while register control owns the pins; testOutput clears to 0 instead.
	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			oversample128Mode <= `CPMD_SPEED_RST;
			oversample256Mode <= ~`CPMD_SPEED_RST;
			formatSelect0 <= `CPMD_FMT_RST;
			formatSelect1 <= `CPMD_FMT_RST;
			soundCharacterSelect <= `CPMD_SOUND_RST;
			testOutput <= 1'h0;
		end else if (styleS) begin
			oversample128Mode <= speedS;
			oversample256Mode <= ~speedS;
			formatSelect0 <= sh0S;
			formatSelect1 <= sh1S;
			soundCharacterSelect <= soundS;
			// A low test input in pin control is a board fault worth flagging.
			testOutput <= ~t18S;
		end else begin
			testOutput <= 1'h0;
		end
	end

	// Address straps are only meaningful in register control.
	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			chipAddrBit0 <= `CPMD_ADDR_RST;
			chipAddrBit1 <= `CPMD_ADDR_RST;
		end else if (!styleS) begin
			chipAddrBit0 <= soundS;
			chipAddrBit1 <= t18S;
		end
	end

	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			muteActive <= `CPMD_MUTE_RST;
		end else begin
			muteActive <= ~muteS;
		end
	end

	// The serial engine sees idle levels unless its own port is selected.
	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			ctrlChipSelectN <= `CPMD_CS_IDLE;
			ctrlSerialClock <= `CPMD_CLK_IDLE;
			ctrlSerialDataIn <= `CPMD_DATA_IDLE;
			i2cScl <= 1'h1;
			i2cSdaIn <= 1'h1;
			serialDataPinOut <= 1'h0;
			serialDataPinOe <= 1'h0;
		end else begin
			ctrlChipSelectN <= `CPMD_CS_IDLE;
			ctrlSerialClock <= `CPMD_CLK_IDLE;
			ctrlSerialDataIn <= `CPMD_DATA_IDLE;
			i2cScl <= 1'h1;
			i2cSdaIn <= 1'h1;
			serialDataPinOut <= 1'h0;
			serialDataPinOe <= 1'h0;
			case (serialKind(styleS, i2cSelS))
				CPMD_SER_3WIRE: begin
					ctrlChipSelectN <= sh0S;
					ctrlSerialClock <= sh1S;
					ctrlSerialDataIn <= sdaS;
				end
				CPMD_SER_I2C: begin
					i2cScl <= sh1S;
					i2cSdaIn <= sdaS;
					// Open drain: only ever pull low.
					serialDataPinOe <= i2cSdaDriveLow;
				end
				CPMD_SER_NONE: begin
					ctrlChipSelectN <= `CPMD_CS_IDLE;
				end
				default: begin
					ctrlChipSelectN <= `CPMD_CS_IDLE;
				end
			endcase
		end
	end

	// The bit clock is oversampled, so it must stay well below half the
	// system clock rate for no edge to be lost.
	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			bclkPrev_reg <= 1'h0;
			multibitWord <= `CPMD_WORD_RST;
			multibitStrobe <= 1'h0;
		end else begin
			bclkPrev_reg <= bclkS;
			multibitStrobe <= bclkRise;
			if (bclkRise) begin
				multibitWord <= dataS;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!coreRstN);

	property p_power_down;
		@(posedge clock) disable iff (!reset_n)
		!powerDownN |-> muteActive && serialPort == CPMD_SER_NONE &&
			!serialDataPinOe && !multibitStrobe;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("not held in power-down");
	property p_style;
		1 |=> controlMode == ($past(styleS) ? CPMD_PIN_CTRL : CPMD_REGISTER_CTRL);
	endproperty
	a_style: assert property (p_style)
		else $error("control style wrong");
	property p_speed;
		styleS |=> oversample128Mode == $past(speedS) &&
			oversample256Mode == !$past(speedS);
	endproperty
	a_speed: assert property (p_speed)
		else $error("speed mode wrong");
	property p_three_wire;
		!styleS && !i2cSelS |=> ctrlChipSelectN == $past(sh0S) &&
			ctrlSerialClock == $past(sh1S) && ctrlSerialDataIn == $past(sdaS);
	endproperty
	a_three_wire: assert property (p_three_wire)
		else $error("3-wire routing wrong");
	property p_i2c;
		!styleS && i2cSelS |=> i2cScl == $past(sh1S) && !serialDataPinOut &&
			serialDataPinOe == $past(i2cSdaDriveLow) && ctrlChipSelectN;
	endproperty
	a_i2c: assert property (p_i2c)
		else $error("I2C routing wrong");
	property p_format;
		styleS |=> formatSelect0 == $past(sh0S) && formatSelect1 == $past(sh1S);
	endproperty
	a_format: assert property (p_format)
		else $error("format select wrong");
	property p_mute;
		muteS ##1 !muteS |=> muteActive ##1 muteActive == !$past(muteS);
	endproperty
	a_mute: assert property (p_mute)
		else $error("mute not following pin");
	property p_sound;
		styleS |=> soundCharacterSelect == $past(soundS);
	endproperty
	a_sound: assert property (p_sound)
		else $error("sound mode wrong");
	property p_addr;
		!styleS |=> chipAddrBit0 == $past(soundS) && chipAddrBit1 == $past(t18S);
	endproperty
	a_addr: assert property (p_addr)
		else $error("chip address wrong");
	property p_word;
		bclkRise |=> multibitStrobe && multibitWord == $past(dataS) ##1
			!multibitStrobe;
	endproperty
	a_word: assert property (p_word)
		else $error("data word not taken");
	// Written out from the rule, not from serialKind, so a slip there shows.
	property p_serial_kind;
		1 |=> serialPort == ($past(styleS) ? CPMD_SER_NONE :
			($past(i2cSelS) ? CPMD_SER_I2C : CPMD_SER_3WIRE));
	endproperty
	a_serial_kind: assert property (p_serial_kind)
		else $error("serial kind wrong");
	property p_ignore;
		!styleS ##1 !styleS |-> $stable(formatSelect0) &&
			$stable(oversample128Mode) && $stable(soundCharacterSelect);
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("pin settings moved");
	property p_idle_serial;
		styleS |=> ctrlChipSelectN && !ctrlSerialClock && !serialDataPinOe;
	endproperty
	a_idle_serial: assert property (p_idle_serial)
		else $error("serial not idle");

	c_pin_mode: cover property (controlMode == CPMD_PIN_CTRL ##1
		oversample128Mode);
	c_i2c_drive: cover property (serialPort == CPMD_SER_I2C && serialDataPinOe);
	c_three_wire: cover property (serialPort == CPMD_SER_3WIRE &&
		!ctrlChipSelectN);
	c_word: cover property (multibitStrobe ##[1:20] multibitStrobe);
endmodule
`default_nettype wire

// File: verification/cpmd_host_model.sv
// Host model: frames multi-bit words and resolves the data wire.
`timescale 1ns/10ps
`default_nettype none
module cpmd_host_model (
	input wire logic clock,
	input wire logic sendReq,
	input wire logic [6:0] sendWord,
	input wire logic i2cMode,
	input wire logic hostBit,
	input wire logic devSdaOe,
	output logic idle,
	output var logic bitClock = 1'h0,
	output var logic [6:0] dataOut = 7'h00,
	output logic sdaLevel
);
	int phase = 0;
	assign idle = (phase == 0);
	// The wire is pulled up in I2C mode, so either party can only pull low.
	assign sdaLevel = i2cMode ? (hostBit & ~devSdaOe) : hostBit;
	always @(posedge clock) begin
		if (phase == 0 && sendReq) begin
			dataOut <= sendWord;
			phase <= 1;
		end else if (phase != 0) begin
			phase <= (phase == 10) ? 0 : phase + 1;
			bitClock <= (phase >= 2 && phase < 5);
			// Once the hold time is over the lines stop showing the word.
			if (phase == 7)
				dataOut <= ~dataOut;
		end
	end
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the control pin mode decoder.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import cpmd_pkg::*;
	logic clock = 1'h0, reset_n = 1'h0, powerDownN = 1'h1, style = 1'h0;
	logic speed = 1'h0, pinA = 1'h1, pinB = 1'h0, pinS = 1'h0, pinT = 1'h1;
	logic muteNA = 1'h1, serType = 1'h0, drvLow = 1'h0, hostBit = 1'h1;
	logic sendReq = 1'h0, idle, bclk, sda, strobe, o256, o128, fmt0, fmt1;
	logic sound, mute, ctrl_chip_select_n, sck, sdi, scl, sdaIn, pOut, pOe, a0, a1, tst;
	logic [6:0] sendWord = 7'h00, mbData, word;
	cpmd_mode_e mode;
	cpmd_serial_e port;
	int miscompares = 0, n_checks = 0, cycles = 0;
	int hSpeed, hF0, hF1, hSnd, hA0, hA1;
	always #5 clock = ~clock;
	cpmd_host_model host (.clock(clock), .sendReq(sendReq),
		.sendWord(sendWord), .i2cMode(!style && serType), .hostBit(hostBit),
		.devSdaOe(pOe), .idle(idle), .bitClock(bclk), .dataOut(mbData),
		.sdaLevel(sda));
	cpmd_decoder dut (.clock(clock), .reset_n(reset_n),
		.powerDownN(powerDownN), .controlStyleSelect(style),
		.speedSelect(speed), .chipSelectFormat0Pin(pinA),
		.serialClockFormat1Pin(pinB), .serialDataPinIn(sda),
		.muteNA(muteNA), .soundAddr0Pin(pinS), .testAddr1Pin(pinT),
		.serialTypeSelect(serType), .multibitBitClock(bclk),
		.multibitDataIn(mbData), .i2cSdaDriveLow(drvLow),
		.controlMode(mode), .serialPort(port), .oversample256Mode(o256),
		.oversample128Mode(o128), .formatSelect0(fmt0),
		.formatSelect1(fmt1), .soundCharacterSelect(sound),
		.muteActive(mute), .ctrlChipSelectN(ctrl_chip_select_n), .ctrlSerialClock(sck),
		.ctrlSerialDataIn(sdi), .i2cScl(scl), .i2cSdaIn(sdaIn),
		.serialDataPinOut(pOut), .serialDataPinOe(pOe),
		.chipAddrBit0(a0), .chipAddrBit1(a1), .testOutput(tst),
		.multibitWord(word), .multibitStrobe(strobe));
	// The planned traffic needs under two thousand cycles.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check_reset();
		hSpeed = 0;
		hF0 = 0;
		hF1 = 0;
		hSnd = 1;
		hA0 = 0;
		hA1 = 0;
		chk(mode, 0);
		chk(port, 0);
		chk(o256, 1);
		chk(mute, 1);
		chk(ctrl_chip_select_n, 1);
		chk(word, 0);
	endtask
	task automatic apply_pins(input int i);
		logic [7:0] r;
		r = 8'($urandom);
		@(posedge clock);
		style <= i[0];
		serType <= i[1];
		speed <= r[0];
		pinA <= r[1];
		pinB <= r[2];
		hostBit <= r[3];
		muteNA <= r[4];
		pinS <= r[5];
		drvLow <= r[6];
		// The test strap stays high in pin control, bar one misstrap step.
		pinT <= (i == 9) ? 1'h0 : (i[0] ? 1'h1 : r[7]);
	endtask
	task automatic check_all();
		logic pin, w3, i2c;
		pin = style;
		w3 = !style && !serType;
		i2c = !style && serType;
		if (pin) begin
			hSpeed = speed;
			hF0 = pinA;
			hF1 = pinB;
			hSnd = pinS;
		end else begin
			hA0 = pinS;
			hA1 = pinT;
		end
		chk(mode, pin);
		chk(port, pin ? 0 : (i2c ? 2 : 1));
		chk(o128, hSpeed);
		chk(o256, !hSpeed);
		chk(fmt0, hF0);
		chk(fmt1, hF1);
		chk(sound, hSnd);
		chk(mute, !muteNA);
		chk(ctrl_chip_select_n, w3 ? pinA : 1'h1);
		chk(sck, w3 && pinB);
		chk(sdi, w3 && hostBit);
		chk(scl, i2c ? pinB : 1'h1);
		chk(sdaIn, i2c ? hostBit && !drvLow : 1'h1);
		chk(pOe, i2c && drvLow);
		chk(pOut, 0);
		chk(a0, hA0);
		chk(a1, hA1);
		chk(tst, pin && !pinT);
	endtask
	task automatic steps(input int a, input int b);
		for (int i = a; i < b; i++) begin
			apply_pins(i);
			repeat (6) @(posedge clock);
			#1;
			check_all();
		end
	endtask
	task automatic send_word();
		logic [6:0] w;
		int n;
		w = 7'($urandom);
		n = 0;
		@(posedge clock);
		sendReq <= 1'h1;
		sendWord <= w;
		@(posedge clock);
		sendReq <= 1'h0;
		#1;
		while (strobe !== 1'h1 && n < 30) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk(strobe, 1);
		chk(word, w);
		@(posedge clock);
		#1;
		chk(strobe, 0);
		while (idle !== 1'h1)
			@(posedge clock);
	endtask
	initial begin
		void'($urandom(68142));
		repeat (16) @(posedge clock);
		#1;
		check_reset();
		@(posedge clock);
		reset_n <= 1'h1;
		steps(0, 40);
		for (int k = 0; k < 8; k++)
			send_word();
		@(posedge clock);
		powerDownN <= 1'h0;
		@(posedge clock);
		#1;
		check_reset();
		@(posedge clock);
		powerDownN <= 1'h1;
		steps(40, 48);
		end_sim();
	end
endmodule
`default_nettype wire
